// File: hdl/sbseq_pkg.sv
// Constants, register map and carrier types for the standstill current,
// holding brake and motor current reporting block.
// Assumes one 250 MHz clock and an object port indexed by index/subindex.
// Behaviour
// - Current reduction starts only after the motor has been still for the idle time in ms, 1000 by default.
// - Reduction acts only in open loop, with its enable bit set and the motor still.
// - A setting from zero up to below the maximum current is the reduced rms current in mA.
// - A setting from -1 to -100 is a percentage: rated times (setting plus 100) over 100.
// - A nominal overload current above zero caps the rated current at the smaller of it and the maximum.
// - After enable is removed and the motor is still, the brake closes once the close delay in ms has passed.
// - After the brake closes the motor current goes off once the power-off delay has passed, 1000 ms by default.
// - On enable the current goes on first and the brake opens after the open delay, 1000 ms by default.
// - After the brake opens the drive enters operation enabled once the start delay has passed, zero by default.
// - The brake is driven as a PWM of 0 to 2000 Hz, zero by default.
// - The brake PWM duty accepts only 0 or 2 to 100 percent, zero by default.
// - Four measured currents, d, q, phase a and phase b, are read-only signed 32-bit mA values.
// - Each measured current is offered for mapping into transmit process data.
// - The maximum current is an rms value in mA.
package sbseq_pkg;
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  // Object indices and subindices
  localparam logic [15:0] IDX_IDLE_TIME = 16'h2036;
  localparam logic [15:0] IDX_REDUCE_SET = 16'h2037;
  localparam logic [15:0] IDX_BRAKE = 16'h2038;
  localparam logic [15:0] IDX_CURRENTS = 16'h2039;
  localparam logic [7:0] SUB_CLOSE = 8'h01;
  localparam logic [7:0] SUB_PWROFF = 8'h02;
  localparam logic [7:0] SUB_OPEN = 8'h03;
  localparam logic [7:0] SUB_START = 8'h04;
  localparam logic [7:0] SUB_FREQ = 8'h05;
  localparam logic [7:0] SUB_DUTY = 8'h06;
  localparam logic [7:0] SUB_ID = 8'h01;
  localparam logic [7:0] SUB_IQ = 8'h02;
  localparam logic [7:0] SUB_IA = 8'h03;
  localparam logic [7:0] SUB_IB = 8'h04;
  localparam logic [31:0] BRAKE_HIGHEST_SUB = 32'h0000_0006;
  localparam logic [31:0] CURR_HIGHEST_SUB = 32'h0000_0004;
  // Reset values
  localparam logic [31:0] RST_IDLE_TIME = 32'h0000_03E8;
  localparam logic [31:0] RST_REDUCE_SET = 32'h0FFF_FFCE;
  localparam logic [31:0] RST_CLOSE = 32'h0000_0000;
  localparam logic [31:0] RST_PWROFF = 32'h0000_03E8;
  localparam logic [31:0] RST_OPEN = 32'h0000_03E8;
  localparam logic [31:0] RST_START = 32'h0000_0000;
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [31:0] RST_DUTY = 32'h0000_0000;
  // Legal ranges
  localparam logic [31:0] FREQ_MAX = 32'h0000_07D0;
  localparam logic [31:0] DUTY_MIN = 32'h0000_0002;
  localparam logic [31:0] DUTY_MAX = 32'h0000_0064;
  localparam logic signed [31:0] PCT_LOW = -32'sh64;
  localparam logic signed [32:0] PCT_BIAS = 33'sh64;
  localparam logic [38:0] PCT_DIV = 39'h64;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } sbseq_obj_req_t;

  typedef struct packed {
    logic signed [31:0] i_d;
    logic signed [31:0] i_q;
    logic signed [31:0] i_a;
    logic signed [31:0] i_b;
  } sbseq_currents_t;
endpackage

// File: hdl/sbseq_brake_pwm.sv
// Brake coil PWM generator.
// Assumes frequency and duty already range-checked by the object port.
`timescale 1ns/1ps
module sbseq_brake_pwm #(
  parameter int unsigned CLK_HZ = sbseq_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic release_en,
  input wire logic [31:0] freq_hz,
  input wire logic [31:0] duty_pct,
  // Coil drive
  output logic coil_q
);
  initial begin
    if (CLK_HZ < 4000 || CLK_HZ > 32'h7FFF_FFFF) begin
      $error("sbseq_brake_pwm: CLK_HZ out of range");
    end
  end

  logic [31:0] phase_q;
  logic [32:0] phase_sum;
  logic [39:0] lhs;
  logic [39:0] rhs;
  logic steady;

  assign phase_sum = {1'b0, phase_q} + {1'b0, freq_hz};
  assign lhs = {8'h00, phase_q} * 40'h64;
  assign rhs = {8'h00, duty_pct} * 40'(CLK_HZ);
  // Zero frequency or zero duty holds the coil steadily on
  assign steady = (freq_hz == 32'h0000_0000) || (duty_pct == 32'h0000_0000);

  // Phase accumulator, one period per CLK_HZ of accumulated frequency
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !release_en || steady) begin
      phase_q <= 32'h0000_0000;
    end else if (phase_sum >= 33'(CLK_HZ)) begin
      phase_q <= 32'(phase_sum - 33'(CLK_HZ));
    end else begin
      phase_q <= phase_sum[31:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      coil_q <= 1'b0;
    end else begin
      coil_q <= release_en && (steady || (lhs < rhs));
    end
  end

  AST_COIL_OFF_CLOSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !release_en |=> !coil_q) else $error("coil driven with brake closed");
  AST_COIL_STEADY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    release_en && freq_hz == 32'h0 |=> coil_q)
    else $error("coil not steady at zero frequency");
endmodule // sbseq_brake_pwm

// File: hdl/sbseq_top.sv
// Standstill current reduction, holding brake sequencer and measured
// current reporting, reached through an object index/subindex port.
// Assumes synchronous inputs, maximum and nominal currents supplied as mA.
`timescale 1ns/1ps
module sbseq_top #(
  parameter int unsigned CYC_PER_MS = sbseq_pkg::CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Object port
  input wire sbseq_pkg::sbseq_obj_req_t obj_req,
  output logic [31:0] obj_rdata_q,
  output logic obj_ack_q,
  output logic obj_err_q,
  // Drive context
  input wire logic open_loop,
  input wire logic reduce_enable,
  input wire logic motor_stationary,
  input wire logic motion_cmd,
  input wire logic enable_req,
  input wire logic [31:0] max_current_ma,
  input wire logic [31:0] nominal_current_ma,
  // Measured currents
  input wire sbseq_pkg::sbseq_currents_t meas_currents,
  // Outputs to the power stage, brake and process data
  output logic [31:0] current_limit_q,
  output logic reduction_active_q,
  output logic current_on_q,
  output logic brake_coil_q,
  output logic op_enabled_q,
  output sbseq_pkg::sbseq_currents_t pdo_currents_q
);
  initial begin
    if (CYC_PER_MS < 2) begin
      $error("sbseq_top: CYC_PER_MS must be at least 2");
    end
  end

  typedef enum logic [5:0] {
    SB_OFF = 6'b000001,
    SB_RELEASE = 6'b000010,
    SB_START = 6'b000100,
    SB_RUN = 6'b001000,
    SB_HOLD = 6'b010000,
    SB_SHUTDN = 6'b100000
  } sbseq_state_t;

  logic [31:0] idle_time_q;
  logic signed [31:0] reduce_set_q;
  logic [31:0] close_dly_q;
  logic [31:0] pwroff_dly_q;
  logic [31:0] open_dly_q;
  logic [31:0] start_dly_q;
  logic [31:0] freq_q;
  logic [31:0] duty_q;
  logic [31:0] tick_cnt_q;
  logic ms_tick_q;
  logic [31:0] idle_ms_q;
  logic [31:0] seq_ms_q;
  sbseq_state_t state_q;
  sbseq_state_t state_d;
  logic brake_release_q;
  logic [31:0] rated;
  logic [6:0] pct_mult;
  logic [38:0] pct_prod;
  logic [31:0] reduced;
  logic set_abs;
  logic set_pct;
  logic reduce_d;
  logic [31:0] limit_d;
  logic wr_bad;

  // Millisecond time base
  always_ff @(posedge sys_clk) begin
    if (sys_rst || tick_cnt_q == 32'(CYC_PER_MS - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (tick_cnt_q == 32'(CYC_PER_MS - 1));
    end
  end

  // Standstill idle timer, restarted by motion
  always_ff @(posedge sys_clk) begin
    if (sys_rst || motion_cmd || !motor_stationary) begin
      idle_ms_q <= 32'h0000_0000;
    end else if (ms_tick_q && idle_ms_q != 32'hFFFF_FFFF) begin
      idle_ms_q <= idle_ms_q + 32'h0000_0001;
    end
  end

  // Rated current and reduced target
  always_comb begin
    rated = max_current_ma;
    if (nominal_current_ma != 32'h0000_0000 &&
        nominal_current_ma < max_current_ma) begin
      rated = nominal_current_ma;
    end
  end

  assign set_abs = !reduce_set_q[31] &&
                   ($unsigned(reduce_set_q) < max_current_ma);
  assign set_pct = reduce_set_q[31] &&
                   (reduce_set_q >= sbseq_pkg::PCT_LOW);
  assign pct_mult = 7'(33'(reduce_set_q) + sbseq_pkg::PCT_BIAS);
  assign pct_prod = {7'h00, rated} * {32'h0000_0000, pct_mult};

  always_comb begin
    reduced = max_current_ma;
    if (set_abs) begin
      reduced = $unsigned(reduce_set_q);
    end else if (set_pct) begin
      reduced = 32'(pct_prod / sbseq_pkg::PCT_DIV);
    end
  end

  assign reduce_d = open_loop && reduce_enable && motor_stationary &&
                    !motion_cmd && (idle_ms_q >= idle_time_q) &&
                    (set_abs || set_pct);

  always_comb begin
    limit_d = 32'h0000_0000;
    if (current_on_q) begin
      limit_d = reduce_d ? reduced : max_current_ma;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reduction_active_q <= 1'b0;
      current_limit_q <= 32'h0000_0000;
    end else begin
      reduction_active_q <= reduce_d;
      current_limit_q <= limit_d;
    end
  end

  // Brake and power sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SB_OFF: begin
        if (enable_req) state_d = SB_RELEASE;
      end
      SB_RELEASE: begin
        if (seq_ms_q >= open_dly_q) state_d = SB_START;
      end
      SB_START: begin
        if (seq_ms_q >= start_dly_q) state_d = SB_RUN;
      end
      SB_RUN: begin
        if (!enable_req) state_d = SB_HOLD;
      end
      SB_HOLD: begin
        if (enable_req) begin
          state_d = SB_RUN;
        end else if (motor_stationary && seq_ms_q >= close_dly_q) begin
          state_d = SB_SHUTDN;
        end
      end
      SB_SHUTDN: begin
        if (enable_req) begin
          state_d = SB_RELEASE;
        end else if (seq_ms_q >= pwroff_dly_q) begin
          state_d = SB_OFF;
        end
      end
      default: state_d = SB_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= SB_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Delay counter, restarted on each step and, in SB_HOLD, while the motor moves
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_d != state_q ||
        (state_q == SB_HOLD && !motor_stationary)) begin
      seq_ms_q <= 32'h0000_0000;
    end else if (ms_tick_q && seq_ms_q != 32'hFFFF_FFFF) begin
      seq_ms_q <= seq_ms_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      current_on_q <= 1'b0;
      brake_release_q <= 1'b0;
      op_enabled_q <= 1'b0;
    end else begin
      current_on_q <= (state_d != SB_OFF);
      brake_release_q <= (state_d == SB_START) || (state_d == SB_RUN) ||
                         (state_d == SB_HOLD);
      op_enabled_q <= (state_d == SB_RUN);
    end
  end

  sbseq_brake_pwm u_pwm (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .release_en(brake_release_q),
    .freq_hz(freq_q),
    .duty_pct(duty_q),
    .coil_q(brake_coil_q)
  );

  // Measured currents to process data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pdo_currents_q <= '0;
    end else begin
      pdo_currents_q <= meas_currents;
    end
  end

  // Object writes; illegal PWM values are refused and keep the old value
  always_comb begin
    wr_bad = 1'b1;
    unique case (obj_req.index)
      sbseq_pkg::IDX_IDLE_TIME,
      sbseq_pkg::IDX_REDUCE_SET: wr_bad = (obj_req.sub != 8'h00);
      sbseq_pkg::IDX_BRAKE: begin
        if (obj_req.sub == sbseq_pkg::SUB_FREQ) begin
          wr_bad = (obj_req.wdata > sbseq_pkg::FREQ_MAX);
        end else if (obj_req.sub == sbseq_pkg::SUB_DUTY) begin
          wr_bad = (obj_req.wdata != 32'h0000_0000) &&
                   ((obj_req.wdata < sbseq_pkg::DUTY_MIN) ||
                    (obj_req.wdata > sbseq_pkg::DUTY_MAX));
        end else begin
          wr_bad = (obj_req.sub < sbseq_pkg::SUB_CLOSE) ||
                   (obj_req.sub > sbseq_pkg::SUB_DUTY);
        end
      end
      default: wr_bad = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_time_q <= sbseq_pkg::RST_IDLE_TIME;
      reduce_set_q <= sbseq_pkg::RST_REDUCE_SET;
      close_dly_q <= sbseq_pkg::RST_CLOSE;
      pwroff_dly_q <= sbseq_pkg::RST_PWROFF;
      open_dly_q <= sbseq_pkg::RST_OPEN;
      start_dly_q <= sbseq_pkg::RST_START;
      freq_q <= sbseq_pkg::RST_FREQ;
      duty_q <= sbseq_pkg::RST_DUTY;
    end else if (obj_req.wr && !wr_bad) begin
      if (obj_req.index == sbseq_pkg::IDX_IDLE_TIME) begin
        idle_time_q <= obj_req.wdata;
      end else if (obj_req.index == sbseq_pkg::IDX_REDUCE_SET) begin
        reduce_set_q <= obj_req.wdata;
      end else begin
        unique case (obj_req.sub)
          sbseq_pkg::SUB_CLOSE: close_dly_q <= obj_req.wdata;
          sbseq_pkg::SUB_PWROFF: pwroff_dly_q <= obj_req.wdata;
          sbseq_pkg::SUB_OPEN: open_dly_q <= obj_req.wdata;
          sbseq_pkg::SUB_START: start_dly_q <= obj_req.wdata;
          sbseq_pkg::SUB_FREQ: freq_q <= obj_req.wdata;
          default: duty_q <= obj_req.wdata;
        endcase
      end
    end
  end

  // Object reads and answers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      obj_rdata_q <= 32'h0000_0000;
      obj_ack_q <= 1'b0;
      obj_err_q <= 1'b0;
    end else begin
      obj_ack_q <= obj_req.wr || obj_req.rd;
      obj_err_q <= obj_req.wr ? wr_bad : 1'b0;
      obj_rdata_q <= 32'h0000_0000;
      if (obj_req.rd) begin
        obj_err_q <= 1'b0;
        unique case ({obj_req.index, obj_req.sub})
          {sbseq_pkg::IDX_IDLE_TIME, 8'h00}: obj_rdata_q <= idle_time_q;
          {sbseq_pkg::IDX_REDUCE_SET, 8'h00}: obj_rdata_q <= reduce_set_q;
          {sbseq_pkg::IDX_BRAKE, 8'h00}:
            obj_rdata_q <= sbseq_pkg::BRAKE_HIGHEST_SUB;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_CLOSE}:
            obj_rdata_q <= close_dly_q;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_PWROFF}:
            obj_rdata_q <= pwroff_dly_q;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_OPEN}:
            obj_rdata_q <= open_dly_q;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_START}:
            obj_rdata_q <= start_dly_q;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_FREQ}: obj_rdata_q <= freq_q;
          {sbseq_pkg::IDX_BRAKE, sbseq_pkg::SUB_DUTY}: obj_rdata_q <= duty_q;
          {sbseq_pkg::IDX_CURRENTS, 8'h00}:
            obj_rdata_q <= sbseq_pkg::CURR_HIGHEST_SUB;
          {sbseq_pkg::IDX_CURRENTS, sbseq_pkg::SUB_ID}:
            obj_rdata_q <= pdo_currents_q.i_d;
          {sbseq_pkg::IDX_CURRENTS, sbseq_pkg::SUB_IQ}:
            obj_rdata_q <= pdo_currents_q.i_q;
          {sbseq_pkg::IDX_CURRENTS, sbseq_pkg::SUB_IA}:
            obj_rdata_q <= pdo_currents_q.i_a;
          {sbseq_pkg::IDX_CURRENTS, sbseq_pkg::SUB_IB}:
            obj_rdata_q <= pdo_currents_q.i_b;
          default: obj_err_q <= 1'b1;
        endcase
      end
    end
  end

  // Checks
  sequence s_brake_closing;
    state_q == SB_HOLD && state_d == SB_SHUTDN;
  endsequence

  AST_IDLE_WAIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(reduction_active_q) |-> $past(idle_ms_q) >= $past(idle_time_q))
    else $error("reduction before idle time");
  AST_REDUCE_GATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reduction_active_q |-> $past(open_loop && reduce_enable &&
                                 motor_stationary))
    else $error("reduction outside open loop standstill");
  AST_ABS_LIMIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reduce_d && set_abs && current_on_q |=>
      current_limit_q == $past(reduce_set_q))
    else $error("absolute reduction wrong");
  AST_PCT_LIMIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reduce_d && set_pct && current_on_q |=>
      current_limit_q == 32'($past(pct_prod) / sbseq_pkg::PCT_DIV))
    else $error("percentage reduction wrong");
  AST_RATED_CAP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nominal_current_ma != 32'h0 |-> rated <= max_current_ma &&
      rated <= nominal_current_ma)
    else $error("rated current not capped");
  AST_CLOSE_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_brake_closing |-> motor_stationary && seq_ms_q >= close_dly_q
      ##1 !brake_release_q ##1 !brake_coil_q)
    else $error("brake closed early");
  AST_POWER_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(current_on_q) |-> !brake_release_q &&
      $past(seq_ms_q) >= $past(pwroff_dly_q))
    else $error("current off too early");
  AST_OPEN_ORDER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(brake_release_q) |-> $past(current_on_q) &&
      $past(seq_ms_q) >= $past(open_dly_q))
    else $error("brake opened before current");
  AST_RUN_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(op_enabled_q) && $past(state_q) == SB_START |-> brake_release_q &&
      $past(seq_ms_q) >= $past(start_dly_q))
    else $error("run before start delay");
  AST_PWM_RANGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    freq_q <= sbseq_pkg::FREQ_MAX)
    else $error("brake pwm frequency out of range");
  AST_DUTY_RANGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    duty_q == 32'h0 || (duty_q >= 32'h2 && duty_q <= 32'h64))
    else $error("brake pwm duty illegal");
  AST_PDO_MIRROR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> pdo_currents_q == $past(meas_currents))
    else $error("process data currents stale");
  AST_MOTION_CANCEL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    motion_cmd && current_on_q |=> !reduction_active_q &&
      current_limit_q == $past(max_current_ma) && idle_ms_q == 32'h0)
    else $error("motion did not cancel reduction");
endmodule // sbseq_top

// File: bench/sbseq_motor_model.sv
// Motor shaft and holding brake stand-in for the standstill/brake bench.
// Assumes the drive outputs are registered on sys_clk.
`timescale 1ns/1ps
module sbseq_motor_model (
  // Clock
  input wire logic sys_clk,
  // Drive side
  input wire logic current_on,
  input wire logic brake_open,
  input wire logic motion_cmd,
  // Shaft state
  output logic motor_stationary
);
  logic [1:0] coast_q = 2'h0;

  // Turns only powered, unbraked and commanded; coasts two cycles
  always_ff @(posedge sys_clk) begin
    if (motion_cmd && current_on && brake_open) begin
      coast_q <= 2'h2;
    end else if (coast_q != 2'h0) begin
      coast_q <= coast_q - 2'h1;
    end
  end
  assign motor_stationary = (coast_q == 2'h0);
endmodule // sbseq_motor_model

// File: bench/test_standstill_current_brake_seq.sv
// Self-checking bench for the standstill, brake and current block.
// Assumes the motor model beside it and a shortened ms tick.
`timescale 1ns/1ps
module test_standstill_current_brake_seq;
  localparam int CPM = 10;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  sbseq_pkg::sbseq_obj_req_t obj_req = '0;
  sbseq_pkg::sbseq_currents_t meas_currents = '0;
  logic open_loop = 1'b1;
  logic reduce_enable = 1'b0;
  logic motion_cmd = 1'b0;
  logic enable_req = 1'b0;
  logic motor_stationary;
  logic [31:0] max_current_ma = 32'h0000_1068;
  logic [31:0] nominal_current_ma = 32'h0;
  logic [31:0] obj_rdata_q, current_limit_q;
  logic obj_ack_q, obj_err_q, reduction_active_q, current_on_q;
  logic brake_coil_q, op_enabled_q;
  sbseq_pkg::sbseq_currents_t pdo_currents_q;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [127:0] mc;
  logic [31:0] seed = 32'h0001_5A1E;
  logic [31:0] dv[5] = '{32'h0, 32'h1, 32'h2, 32'h64, 32'h65};
  logic [31:0] rs[3] = '{32'hFFFF_FFC4, 32'h1F4, 32'hFFFF_FFC4};
  logic [31:0] nm[3] = '{32'h0, 32'h0, 32'hBB8};
  logic [31:0] lim[3] = '{32'h690, 32'h1F4, 32'h4B0};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  always #2 sys_clk = ~sys_clk;

  sbseq_top #(.CYC_PER_MS(CPM)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .obj_req(obj_req),
    .obj_rdata_q(obj_rdata_q), .obj_ack_q(obj_ack_q),
    .obj_err_q(obj_err_q), .open_loop(open_loop),
    .reduce_enable(reduce_enable), .motor_stationary(motor_stationary),
    .motion_cmd(motion_cmd), .enable_req(enable_req),
    .max_current_ma(max_current_ma),
    .nominal_current_ma(nominal_current_ma),
    .meas_currents(meas_currents), .current_limit_q(current_limit_q),
    .reduction_active_q(reduction_active_q),
    .current_on_q(current_on_q), .brake_coil_q(brake_coil_q),
    .op_enabled_q(op_enabled_q), .pdo_currents_q(pdo_currents_q));

  sbseq_motor_model motor (.sys_clk(sys_clk), .current_on(current_on_q),
    .brake_open(brake_coil_q), .motion_cmd(motion_cmd),
    .motor_stationary(motor_stationary));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic pick(int s);
    case (s)
      0: return reduction_active_q;
      1: return current_on_q;
      2: return brake_coil_q;
      3: return op_enabled_q;
      4: return !brake_coil_q;
      default: return !current_on_q;
    endcase
  endfunction

  task automatic chk(string nme, logic [32:0] seen, logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nme, exp, seen);
    end
  endtask

  // One object access; reads expect d, writes expect only the error flag
  task automatic acc(logic w, logic [15:0] i, logic [7:0] s,
                     logic [31:0] d, logic err);
    @(posedge sys_clk);
    obj_req <= '{w, !w, i, s, w ? d : 32'h0};
    exp_q.push_back({w, err, w ? 32'h0 : d});
    @(posedge sys_clk);
    obj_req.wr <= 1'b0;
    obj_req.rd <= 1'b0;
  endtask

  task automatic wt(int s, int lm, string nme);
    n = 0;
    while (pick(s) !== 1'b1 && n < lm) begin
      @(negedge sys_clk);
      n++;
    end
    chk(nme, {32'h0, n < lm}, 33'h1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(negedge sys_clk) begin
    if (obj_ack_q === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~34'h0;
      chk("object", {obj_err_q, e[33] ? 32'h0 : obj_rdata_q}, e[32:0]);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    acc(0, 16'h2036, 8'h00, 32'h3E8, 0);
    acc(0, 16'h2037, 8'h00, 32'h0FFF_FFCE, 0);
    acc(0, 16'h2038, 8'h00, 32'h6, 0);
    acc(0, 16'h2038, 8'h01, 32'h0, 0);
    acc(0, 16'h2038, 8'h02, 32'h3E8, 0);
    acc(0, 16'h2038, 8'h03, 32'h3E8, 0);
    acc(0, 16'h2038, 8'h04, 32'h0, 0);
    acc(0, 16'h2038, 8'h05, 32'h0, 0);
    acc(0, 16'h2038, 8'h06, 32'h0, 0);
    acc(0, 16'h2039, 8'h00, 32'h4, 0);
    $display("test defaults done");
    acc(1, 16'h2038, 8'h05, 32'h7D0, 0);
    acc(1, 16'h2038, 8'h05, 32'h7D1, 1);
    acc(0, 16'h2038, 8'h05, 32'h7D0, 0);
    foreach (dv[i]) begin
      acc(1, 16'h2038, 8'h06, dv[i],
          dv[i] == 32'h1 || dv[i] > 32'h64);
    end
    acc(0, 16'h2038, 8'h06, 32'h64, 0);
    acc(1, 16'h2039, 8'h01, 32'h5, 1);
    acc(0, 16'h2040, 8'h00, 32'h0, 1);
    @(posedge sys_clk);
    mc = {rnd(), rnd(), rnd(), rnd()};
    meas_currents <= mc;
    for (int k = 1; k < 5; k++) begin
      acc(0, 16'h2039, 8'(k), mc[159-32*k -: 32], 0);
    end
    chk("pdo_ib", {1'b0, pdo_currents_q.i_b}, {1'b0, mc[31:0]});
    $display("test objects done");
    acc(1, 16'h2038, 8'h05, 32'h0, 0);
    acc(1, 16'h2038, 8'h06, 32'h0, 0);
    acc(1, 16'h2038, 8'h01, 32'h1, 0);
    acc(1, 16'h2038, 8'h02, 32'h2, 0);
    acc(1, 16'h2038, 8'h03, 32'h2, 0);
    acc(1, 16'h2038, 8'h04, 32'h1, 0);
    @(posedge sys_clk);
    enable_req <= 1'b1;
    wt(1, 4, "current_on");
    chk("brake_early", {32'h0, brake_coil_q}, 33'h0);
    wt(2, 40, "brake_open");
    chk("open_delay", {32'h0, n >= 8}, 33'h1);
    wt(3, 30, "op_enabled");
    repeat (20) begin
      @(negedge sys_clk);
      chk("coil_steady", {32'h0, brake_coil_q}, 33'h1);
    end
    $display("test release done");
    acc(1, 16'h2036, 8'h00, 32'h3, 0);
    repeat (60) @(posedge sys_clk);
    chk("no_enable", {32'h0, reduction_active_q}, 33'h0);
    reduce_enable <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      motion_cmd <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("motion", {reduction_active_q, current_limit_q},
          {1'b0, max_current_ma});
      acc(1, 16'h2037, 8'h00, rs[k], 0);
      nominal_current_ma <= nm[k];
      motion_cmd <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("idle_early", {32'h0, reduction_active_q}, 33'h0);
      wt(0, 80, "reduced");
      chk("limit", {1'b0, current_limit_q},
          {1'b0, lim[k]});
    end
    @(posedge sys_clk);
    open_loop <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("closed_loop", {32'h0, reduction_active_q}, 33'h0);
    $display("test reduction done");
    @(posedge sys_clk);
    enable_req <= 1'b0;
    wt(4, 40, "brake_closed");
    chk("power_kept", {32'h0, current_on_q}, 33'h1);
    wt(5, 40, "power_off");
    chk("pwroff_delay", {32'h0, n >= 8}, 33'h1);
    @(negedge sys_clk);
    chk("limit_off", {1'b0, current_limit_q}, 33'h0);
    $display("test hold done");
    end_sim();
  end
endmodule // test_standstill_current_brake_seq
